/* design/osc_ctrl_defines.svh */
`ifndef OSC_CTRL_DEFINES_SVH
`define OSC_CTRL_DEFINES_SVH

// Register addresses on the plain register port.
`define OSC_CTRL_ADDR 12'hf86
`define OSC_STATUS_ADDR 12'hf87

// Reset value of the oscillator control register.
`define OSC_CTRL_RESET 8'ha0

// Unlock key values, written in this order.
`define UNLOCK_KEY_FIRST 8'he7
`define UNLOCK_KEY_SECOND 8'h18

// Field positions in the oscillator control register.
`define BIT_INT_EN 7
`define BIT_XTL_EN 6
`define BIT_WDT_EN 5
`define BIT_SYS_FD 4
`define BIT_WDT_FD 3
`define SEL_MSB 2
`define SEL_LSB 0

// Field positions in the status register.
`define ST_SYS_FAIL 7
`define ST_WDT_FAIL 6
`define ST_HALT 5
`define ST_LOCK_MSB 4
`define ST_LOCK_LSB 3

// Clock period and the dead-source timeout.
`define CLK_PERIOD_PS 4000
`define FAIL_TIME_NS 1000
`define FAIL_CYCLES ((`FAIL_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

/* design/osc_ctrl_pkg.sv */
package osc_ctrl_pkg;

    // Progress through the unlock sequence.
    typedef enum logic [1:0] {
        LOCKED = 2'b00,
        KEY_SEEN = 2'b01,
        OPEN = 2'b10
    } lock_state_t;

    // Encoding of the system clock source select field.
    typedef enum logic [2:0] {
        SRC_INT_FAST = 3'b000,
        SRC_INT_SLOW = 3'b001,
        SRC_CRYSTAL = 3'b010,
        SRC_WATCHDOG = 3'b011,
        SRC_EXTERNAL = 3'b100
    } clk_src_t;

endpackage

/* design/oscillator_control_lock.sv */
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "osc_ctrl_defines.svh"

module oscillator_control_lock
    import osc_ctrl_pkg::*;
#(
    parameter int FAIL_COUNT = `FAIL_CYCLES
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [11:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic [3:0] osc_alive,
    input wire logic gpio_pin_a_oe,
    input wire logic gpio_pin_a_out,
    input wire logic gpio_pin_b_oe,
    input wire logic gpio_pin_b_out,
    output logic crystal_pin_a_oe,
    output logic crystal_pin_a_out,
    output logic crystal_pin_b_oe,
    output logic crystal_pin_b_out,
    output logic internal_osc_enable,
    output logic internal_rate_slow,
    output logic crystal_osc_enable,
    output logic watchdog_osc_enable,
    output logic sysclk_fail_detect_enable,
    output logic watchdog_osc_fail_detect_enable,
    output logic [2:0] sysclk_source_select,
    output logic device_halt
);

    // Counter width covers the timeout with one spare bit.
    localparam int CW = $clog2(FAIL_COUNT + 1) + 1;

    // Alive indices: 0 internal, 1 crystal, 2 watchdog, 3 external clock.
    logic [3:0] alive_meta_reg; // First synchroniser stage, read only by the second.
    logic [3:0] alive_reg; // Synchronised oscillator running indications.
    logic [7:0] ctrl_reg; // Stored oscillator control value.
    lock_state_t lock_reg; // Unlock sequence state.
    logic override_reg; // Hardware recovery has taken over the source choice.
    clk_src_t override_src_reg; // Source chosen by recovery.
    clk_src_t eff_src_reg; // Source actually driving the system clock.
    logic [CW-1:0] sys_dead_reg; // Cycles the chosen source has looked dead.
    logic [CW-1:0] wdt_dead_reg; // Cycles the watchdog oscillator has looked dead.
    logic sys_fail_reg; // Sticky system clock failure flag.
    logic wdt_fail_reg; // Sticky watchdog oscillator failure flag.
    logic halt_reg; // Sticky stop; only the power-on reset clears it.

    // Decoded accesses and dead-time events.
    logic ctrl_wr;
    logic status_wr;
    logic sys_dead_evt;
    logic wdt_dead_evt;
    assign ctrl_wr = wr && (addr == `OSC_CTRL_ADDR) && !halt_reg;
    assign status_wr = wr && (addr == `OSC_STATUS_ADDR) && !halt_reg;
    assign sys_dead_evt = (sys_dead_reg == CW'(FAIL_COUNT));
    assign wdt_dead_evt = (wdt_dead_reg == CW'(FAIL_COUNT));

    // Whether a select code names a known source.
    function automatic logic src_valid(input logic [2:0] sel);
        begin
            src_valid = (sel <= SRC_EXTERNAL);
        end
    endfunction

    // Running indication of the oscillator behind a select code.
    function automatic logic src_alive(input logic [2:0] sel, input logic [3:0] alive);
        begin
            case (sel)
                SRC_INT_FAST, SRC_INT_SLOW: src_alive = alive[0];
                SRC_CRYSTAL: src_alive = alive[1];
                SRC_WATCHDOG: src_alive = alive[2];
                SRC_EXTERNAL: src_alive = alive[3];
                default: src_alive = 1'b0;
            endcase
        end
    endfunction

    // The running indications come from analog circuits on other clocks.
    always_ff @(posedge clock) begin
        if (srst) begin
            alive_meta_reg <= 4'h0;
            alive_reg <= 4'h0;
        end else begin
            alive_meta_reg <= osc_alive;
            alive_reg <= alive_meta_reg;
        end
    end

    // Unlock sequencer; only writes to the control address move it.
    always_ff @(posedge clock) begin
        if (srst) begin
            lock_reg <= LOCKED;
        end else if (ctrl_wr) begin
            case (lock_reg)
                LOCKED: begin
                    if (wdata == `UNLOCK_KEY_FIRST) begin
                        lock_reg <= KEY_SEEN;
                    end
                end
                KEY_SEEN: begin
                    // A repeated first key restarts the pair rather than failing it.
                    if (wdata == `UNLOCK_KEY_SECOND) begin
                        lock_reg <= OPEN;
                    end else if (wdata == `UNLOCK_KEY_FIRST) begin
                        lock_reg <= KEY_SEEN;
                    end else begin
                        lock_reg <= LOCKED;
                    end
                end
                OPEN: begin
                    lock_reg <= LOCKED;
                end
                default: begin
                    lock_reg <= LOCKED;
                end
            endcase
        end
    end

    // The stored value changes only on the write that follows a full unlock.
    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl_reg <= `OSC_CTRL_RESET;
        end else if (ctrl_wr && (lock_reg == OPEN)) begin
            ctrl_reg <= wdata;
        end
    end

    // Dead-time counters saturate one past the timeout so the event fires once.
    always_ff @(posedge clock) begin
        if (srst || src_alive(eff_src_reg, alive_reg)) begin
            sys_dead_reg <= '0;
        end else if (sys_dead_reg <= CW'(FAIL_COUNT)) begin
            sys_dead_reg <= sys_dead_reg + CW'(1);
        end
    end

    // The watchdog counter only runs while its failure detection is armed.
    always_ff @(posedge clock) begin
        if (srst || alive_reg[2] || !ctrl_reg[`BIT_WDT_FD] || !ctrl_reg[`BIT_WDT_EN]) begin
            wdt_dead_reg <= '0;
        end else if (wdt_dead_reg <= CW'(FAIL_COUNT)) begin
            wdt_dead_reg <= wdt_dead_reg + CW'(1);
        end
    end

    // Recovery moves to the watchdog oscillator, or off it when it fails.
    // A new effective control write hands the choice back to software.
    always_ff @(posedge clock) begin
        if (srst) begin
            override_reg <= 1'b0;
            override_src_reg <= SRC_INT_FAST;
        end else if (sys_dead_evt && ctrl_reg[`BIT_SYS_FD]) begin
            override_reg <= 1'b1;
            override_src_reg <= (eff_src_reg == SRC_WATCHDOG) ? SRC_INT_FAST : SRC_WATCHDOG;
        end else if (wdt_dead_evt && eff_src_reg == SRC_WATCHDOG) begin
            override_reg <= 1'b1;
            override_src_reg <= SRC_INT_FAST;
        end else if (ctrl_wr && (lock_reg == OPEN)) begin
            override_reg <= 1'b0;
        end
    end

    // Effective source; a reserved select code keeps the previous source.
    always_ff @(posedge clock) begin
        if (srst) begin
            eff_src_reg <= SRC_INT_FAST;
        end else if (override_reg) begin
            eff_src_reg <= override_src_reg;
        end else if (src_valid(ctrl_reg[`SEL_MSB:`SEL_LSB])) begin
            eff_src_reg <= clk_src_t'(ctrl_reg[`SEL_MSB:`SEL_LSB]);
        end
    end

    // Sticky failure flags; writing ones clears them, but a new event wins.
    always_ff @(posedge clock) begin
        if (srst) begin
            sys_fail_reg <= 1'b0;
            wdt_fail_reg <= 1'b0;
        end else begin
            if (sys_dead_evt && ctrl_reg[`BIT_SYS_FD]) begin
                sys_fail_reg <= 1'b1;
            end else if (status_wr && wdata[`ST_SYS_FAIL]) begin
                sys_fail_reg <= 1'b0;
            end
            if (wdt_dead_evt) begin
                wdt_fail_reg <= 1'b1;
            end else if (status_wr && wdata[`ST_WDT_FAIL]) begin
                wdt_fail_reg <= 1'b0;
            end
        end
    end

    // With detection off, a dead clock stops the part until power-on reset.
    always_ff @(posedge clock) begin
        if (srst) begin
            halt_reg <= 1'b0;
        end else if (sys_dead_evt && !ctrl_reg[`BIT_SYS_FD]) begin
            halt_reg <= 1'b1;
        end
    end

    // Oscillator enables; recovery keeps its chosen source running.
    always_ff @(posedge clock) begin
        if (srst) begin
            internal_osc_enable <= 1'b0;
            internal_rate_slow <= 1'b0;
            crystal_osc_enable <= 1'b0;
            watchdog_osc_enable <= 1'b0;
            sysclk_fail_detect_enable <= 1'b0;
            watchdog_osc_fail_detect_enable <= 1'b0;
            sysclk_source_select <= SRC_INT_FAST;
            device_halt <= 1'b0;
        end else begin
            internal_osc_enable <= ctrl_reg[`BIT_INT_EN]
                || (override_reg && override_src_reg == SRC_INT_FAST);
            internal_rate_slow <= (eff_src_reg == SRC_INT_SLOW);
            crystal_osc_enable <= ctrl_reg[`BIT_XTL_EN];
            watchdog_osc_enable <= ctrl_reg[`BIT_WDT_EN]
                || (override_reg && override_src_reg == SRC_WATCHDOG);
            sysclk_fail_detect_enable <= ctrl_reg[`BIT_SYS_FD];
            watchdog_osc_fail_detect_enable <= ctrl_reg[`BIT_WDT_FD];
            sysclk_source_select <= eff_src_reg;
            device_halt <= halt_reg;
        end
    end

    // The crystal takes both pins away from the port logic.
    always_ff @(posedge clock) begin
        if (srst) begin
            crystal_pin_a_oe <= 1'b0;
            crystal_pin_a_out <= 1'b0;
            crystal_pin_b_oe <= 1'b0;
            crystal_pin_b_out <= 1'b0;
        end else begin
            crystal_pin_a_oe <= gpio_pin_a_oe && !ctrl_reg[`BIT_XTL_EN];
            crystal_pin_a_out <= gpio_pin_a_out && !ctrl_reg[`BIT_XTL_EN];
            crystal_pin_b_oe <= gpio_pin_b_oe && !ctrl_reg[`BIT_XTL_EN];
            crystal_pin_b_out <= gpio_pin_b_out && !ctrl_reg[`BIT_XTL_EN];
        end
    end

    // Read data stand in the cycle after the read strobe only.
    always_ff @(posedge clock) begin
        if (srst || !rd) begin
            rdata <= 8'h00;
        end else if (addr == `OSC_CTRL_ADDR) begin
            rdata <= ctrl_reg;
        end else if (addr == `OSC_STATUS_ADDR) begin
            rdata <= {sys_fail_reg, wdt_fail_reg, halt_reg, lock_reg, eff_src_reg};
        end else begin
            rdata <= 8'h00;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    a_locked_ignore: assert property (
        (ctrl_wr && lock_reg != OPEN) |=> $stable(ctrl_reg)
    ) else $error("control changed without unlock");

    a_first_key: assert property (
        (ctrl_wr && lock_reg == LOCKED && wdata == `UNLOCK_KEY_FIRST) |=> lock_reg == KEY_SEEN
    ) else $error("first key not taken");

    a_second_key: assert property (
        (ctrl_wr && lock_reg == KEY_SEEN && wdata == `UNLOCK_KEY_SECOND) |=> lock_reg == OPEN
    ) else $error("second key not taken");

    a_store_relock: assert property (
        (ctrl_wr && lock_reg == OPEN) |=> (ctrl_reg == $past(wdata) && lock_reg == LOCKED)
    ) else $error("unlocked write not stored or not relocked");

    a_other_access: assert property (
        !ctrl_wr |=> $stable(lock_reg)
    ) else $error("unlock state moved by other access");

    a_gap_kept: assert property (
        (lock_reg == KEY_SEEN && !ctrl_wr) [*3] |=> lock_reg == KEY_SEEN
    ) else $error("first key lost across a gap");

    a_int_enable: assert property (
        (!override_reg && ctrl_reg[`BIT_INT_EN] == 1'b0) ##1 !override_reg |-> !internal_osc_enable
    ) else $error("internal oscillator enabled while bit clear");

    a_pin_release: assert property (
        ctrl_reg[`BIT_XTL_EN] |=> (!crystal_pin_a_oe && !crystal_pin_b_oe && crystal_osc_enable)
    ) else $error("port drives crystal pins");

    a_wdt_enable: assert property (
        ctrl_reg[`BIT_WDT_EN] |=> watchdog_osc_enable
    ) else $error("watchdog oscillator not running");

    a_recover: assert property (
        (sys_dead_evt && ctrl_reg[`BIT_SYS_FD]) |=> override_reg ##1 eff_src_reg == $past(override_src_reg)
    ) else $error("no recovery after clock failure");

    a_halt_sticky: assert property (
        (sys_dead_evt && !ctrl_reg[`BIT_SYS_FD]) |=> halt_reg ##1 (halt_reg && device_halt)
    ) else $error("halt not taken or not held");

    a_slow_rate: assert property (
        (eff_src_reg == SRC_INT_SLOW) |=> internal_rate_slow
    ) else $error("slow internal rate not applied");

    c_unlock_write: cover property (
        ctrl_wr && lock_reg == OPEN
    );
    c_unlock_gap: cover property (
        lock_reg == KEY_SEEN && !ctrl_wr && (rd || wr)
    );
    c_recovery: cover property (
        sys_dead_evt && ctrl_reg[`BIT_SYS_FD]
    );
    c_halt: cover property (
        $rose(halt_reg)
    );

endmodule

`default_nettype wire

/* dv/oscillator_control_lock_tb.sv */
`timescale 1ns/10ps
`default_nettype none

module oscillator_control_lock_tb
    import osc_ctrl_pkg::*;
;
    // A short dead-source count keeps the failure tests brief.
    localparam int FAIL_SIM = 8;
    // Cycle ceiling; the whole sequence needs well under a thousand.
    localparam int LIMIT = 20000;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [11:0] addr = 12'h000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [3:0] osc_alive = 4'hf;
    logic ga_oe = 1'b0;
    logic ga_out = 1'b0;
    logic gb_oe = 1'b0;
    logic gb_out = 1'b0;
    logic pa_oe, pa_out, pb_oe, pb_out;
    logic int_en, slow, xtl_en, wdt_en, sys_fd, wdt_fd, halt;
    logic [2:0] sel;
    int fails = 0;
    int compares = 0;
    int cycles = 0;

    oscillator_control_lock #(.FAIL_COUNT(FAIL_SIM)) uut (
        .clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .osc_alive(osc_alive), .gpio_pin_a_oe(ga_oe),
        .gpio_pin_a_out(ga_out), .gpio_pin_b_oe(gb_oe), .gpio_pin_b_out(gb_out),
        .crystal_pin_a_oe(pa_oe), .crystal_pin_a_out(pa_out),
        .crystal_pin_b_oe(pb_oe), .crystal_pin_b_out(pb_out),
        .internal_osc_enable(int_en), .internal_rate_slow(slow),
        .crystal_osc_enable(xtl_en), .watchdog_osc_enable(wdt_en),
        .sysclk_fail_detect_enable(sys_fd), .watchdog_osc_fail_detect_enable(wdt_fd),
        .sysclk_source_select(sel), .device_halt(halt)
    );

    // Free-running 250 MHz clock.
    initial begin
        forever #2 clock = ~clock;
    end

    // Cuts a hang short and still reaches the verdict.
    always @(posedge clock) begin
        cycles++;
        if (cycles == LIMIT) begin
            fails++;
            finish_test();
        end
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One-cycle write strobe, changed just after the edge.
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Derived outputs trail the stored value by one or two more edges.
    task automatic unlock_write(input logic [7:0] v);
        wr_reg(12'hf86, 8'he7);
        wr_reg(12'hf86, 8'h18);
        wr_reg(12'hf86, v);
        repeat (3) @(posedge clock);
        #1;
    endtask

    task automatic do_reset();
        @(posedge clock);
        srst <= 1'b1;
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        repeat (4) @(posedge clock);
        #1;
    endtask

    task automatic test_reset();
        logic [7:0] d;
        rd_reg(12'hf86, d);
        check("ctrl reset", d, 8'ha0);
        check("int en", {7'h0, int_en}, 8'h01);
        check("wdt en", {7'h0, wdt_en}, 8'h01);
        check("sel reset", {5'h0, sel}, {5'h0, SRC_INT_FAST});
        $display("test_reset done");
    endtask

    // Writes without the ordered key pair never land.
    task automatic test_locked();
        logic [7:0] d;
        wr_reg(12'hf86, 8'h55);
        wr_reg(12'hf86, 8'h18);
        wr_reg(12'hf86, 8'h3c);
        wr_reg(12'hf86, 8'he7);
        wr_reg(12'hf86, 8'h55);
        wr_reg(12'hf86, 8'h18);
        wr_reg(12'hf86, 8'h3c);
        rd_reg(12'hf86, d);
        check("locked", d, 8'ha0);
        $display("test_locked done");
    endtask

    // Keys split by other accesses still unlock.
    task automatic test_unlock();
        logic [7:0] d;
        wr_reg(12'hf86, 8'he7);
        rd_reg(12'hf87, d);
        check("key seen", {6'h0, d[4:3]}, 8'h01);
        wr_reg(12'hf00, 8'hff);
        rd_reg(12'hf86, d);
        check("mid ctrl", d, 8'ha0);
        wr_reg(12'hf86, 8'h18);
        rd_reg(12'hf87, d);
        check("open", {6'h0, d[4:3]}, 8'h02);
        // The pair is already in, so this single write is the one that lands.
        wr_reg(12'hf86, 8'h5a);
        repeat (3) @(posedge clock);
        #1;
        check("int off", {7'h0, int_en}, 8'h00);
        check("xtl on", {7'h0, xtl_en}, 8'h01);
        check("wdt off", {7'h0, wdt_en}, 8'h00);
        check("sys fd", {7'h0, sys_fd}, 8'h01);
        check("wdt fd", {7'h0, wdt_fd}, 8'h01);
        wr_reg(12'hf86, 8'h00);
        rd_reg(12'hf86, d);
        check("relocked", d, 8'h5a);
        $display("test_unlock done");
    endtask

    // The crystal enable takes the pins away from the port logic.
    task automatic test_pins();
        @(posedge clock);
        {ga_oe, ga_out, gb_oe, gb_out} <= 4'b1110;
        repeat (2) @(posedge clock);
        #1;
        check("pins held", {4'h0, pa_oe, pa_out, pb_oe, pb_out}, 8'h00);
        unlock_write(8'ha0);
        check("pins free", {4'h0, pa_oe, pa_out, pb_oe, pb_out}, 8'h0e);
        $display("test_pins done");
    endtask

    // Crystal, watchdog and the external pin already run before they are picked.
    task automatic test_select();
        for (int c = 0; c < 5; c++) begin
            unlock_write(8'he0 | 8'(c));
            check("select", {5'h0, sel}, 8'(c));
            check("slow", {7'h0, slow}, {7'h0, c == 1});
        end
        unlock_write(8'he5);
        check("reserved", {5'h0, sel}, 8'h04);
        $display("test_select done");
    endtask

    task automatic test_wdt_fail();
        logic [7:0] d;
        unlock_write(8'ha8);
        @(posedge clock);
        osc_alive <= 4'hb;
        d = 8'h00;
        for (int i = 0; i < 40 && d[6] !== 1'b1; i++) rd_reg(12'hf87, d);
        check("wdt fail", {7'h0, d[6]}, 8'h01);
        @(posedge clock);
        osc_alive <= 4'hf;
        wr_reg(12'hf87, 8'h40);
        rd_reg(12'hf87, d);
        check("wdt clear", {7'h0, d[6]}, 8'h00);
        $display("test_wdt_fail done");
    endtask

    // A dead crystal with detection on falls back to the watchdog source.
    task automatic test_recovery();
        logic [7:0] d;
        // The crystal is started first and picked only once it runs.
        unlock_write(8'hf0);
        unlock_write(8'hf2);
        @(posedge clock);
        osc_alive <= 4'hd;
        for (int i = 0; i < 40 && sel !== SRC_WATCHDOG; i++) @(posedge clock);
        #1;
        check("recover", {5'h0, sel}, {5'h0, SRC_WATCHDOG});
        rd_reg(12'hf87, d);
        check("sys flag", {7'h0, d[7]}, 8'h01);
        check("no halt", {7'h0, halt}, 8'h00);
        @(posedge clock);
        osc_alive <= 4'hf;
        unlock_write(8'he0);
        wr_reg(12'hf87, 8'h80);
        $display("test_recovery done");
    endtask

    // Without detection a dead source stops the part until reset.
    task automatic test_halt();
        logic [7:0] d;
        unlock_write(8'hc2);
        @(posedge clock);
        osc_alive <= 4'hd;
        for (int i = 0; i < 40 && halt !== 1'b1; i++) @(posedge clock);
        #1;
        check("halt", {7'h0, halt}, 8'h01);
        unlock_write(8'ha0);
        rd_reg(12'hf86, d);
        check("halt frozen", d, 8'hc2);
        @(posedge clock);
        osc_alive <= 4'hf;
        do_reset();
        check("halt cleared", {7'h0, halt}, 8'h00);
        $display("test_halt done");
    endtask

    task automatic finish_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        do_reset();
        test_reset();
        test_locked();
        test_unlock();
        test_pins();
        test_select();
        test_wdt_fail();
        test_recovery();
        test_halt();
        finish_test();
    end
endmodule

`default_nettype wire
